//--- verilog/pulse_mode_pkg.sv
package pulse_mode_pkg;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_IRQ    = 4'h8;
  localparam logic [3:0] OFS_MASK   = 4'hC;

  // control register field positions
  localparam int CTRL_OC_BIT   = 0;
  localparam int CTRL_OT_BIT   = 1;

  // interrupt bit positions
  localparam int IRQ_LATCH_BIT = 0;
  localparam int IRQ_SHUTDOWN_PULSE_PIN_BIT  = 1;
  localparam int IRQ_OC_BIT    = 2;
  localparam int IRQ_OT_BIT    = 3;
  localparam int IRQ_W         = 4;

  localparam logic [IRQ_W-1:0] MASK_RESET = 4'h0;

  // timing
  localparam int CLK_HZ          = 50_000_000;
  localparam int DEGLITCH_NS     = 200;
  localparam int SETTLE_US       = 100;
  localparam int OFF_HOLD_US     = 1000;
  localparam int DEGLITCH_CYCLES = DEGLITCH_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int SETTLE_CYCLES   = SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int OFF_HOLD_CYCLES = OFF_HOLD_US * (CLK_HZ / 1_000_000);
  localparam int MAX_EDGES       = 4;

  typedef enum logic [2:0]
  {
    ST_SHUTDOWN = 3'b000,
    ST_COUNT    = 3'b001,
    ST_RUN      = 3'b010,
    ST_FAULT    = 3'b011
  } link_state_t;

  // mode code: 0 none, 1..4 modes
  typedef enum logic [2:0]
  {
    MODE_NONE = 3'b000,
    MODE_1P2W = 3'b001,
    MODE_1W   = 3'b010,
    MODE_0P8W = 3'b011,
    MODE_OFF  = 3'b100
  } op_mode_t;

  typedef struct packed
  {
    logic       enable;       // amplifier outputs driven
    logic       limiter_on;   // clip limiter active
    logic [1:0] power_level;  // 0 1.2W, 1 1W, 2 0.8W
  } amp_ctrl_t;

endpackage

//--- verilog/pin_deglitch.sv
`timescale 1ns/1ps
module pin_deglitch
  import pulse_mode_pkg::*;
#(
  parameter int STABLE_CYCLES = DEGLITCH_CYCLES
)
(
  input  wire logic clk_sys,   // system clock
  input  wire logic arst_n,    // async reset
  input  wire logic pin_raw,   // asynchronous pin
  output logic      pin_clean  // filtered level
);

  localparam int CW = $clog2(STABLE_CYCLES + 1);

  initial
  begin
    if (STABLE_CYCLES < 1)
      $error("stable cycles must be at least one");
  end

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] run;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  // level must hold before it is passed on
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run       <= '0;
      pin_clean <= 1'b0;
    end
    else if (sync_b == pin_clean)
      run <= '0;
    else if (run == CW'(STABLE_CYCLES - 1))
    begin
      run       <= '0;
      pin_clean <= sync_b;
    end
    else
      run <= run + 1'b1;
  end

endmodule

//--- verilog/fault_monitor.sv
`timescale 1ns/1ps
module fault_monitor
(
  input  wire logic clk_sys,    // system clock
  input  wire logic arst_n,     // async reset
  input  wire logic flag_raw,   // asynchronous detector level
  output logic      flag_sync   // synchronised level
);

  logic stage_a;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage_a   <= 1'b0;
      flag_sync <= 1'b0;
    end
    else
    begin
      stage_a   <= flag_raw;
      flag_sync <= stage_a;
    end
  end

endmodule

//--- verilog/pulse_count_mode_select.sv
`timescale 1ns/1ps
module pulse_count_mode_select
  import pulse_mode_pkg::*;
#(
  parameter int SETTLE_CNT   = SETTLE_CYCLES,
  parameter int OFF_HOLD_CNT = OFF_HOLD_CYCLES,
  parameter int GLITCH_CNT   = DEGLITCH_CYCLES
)
(
  input  wire logic        clk_sys,             // 50 MHz clock
  input  wire logic        arst_n,              // async reset
  input  wire logic        shutdown_pulse_pin,  // host control pin
  input  wire logic        over_current_raw,    // short detector level
  input  wire logic        over_temp_raw,       // thermal detector level
  input  wire logic [3:0]  avs_address,         // byte address
  input  wire logic        avs_read,            // read strobe
  input  wire logic        avs_write,           // write strobe
  input  wire logic [31:0] avs_writedata,       // write data
  input  wire logic [3:0]  avs_byteenable,      // byte lanes
  output logic [31:0]      avs_readdata,        // read data
  output logic             avs_waitrequest,     // stall
  output logic             irq,                 // level interrupt
  output amp_ctrl_t        amp_ctrl,            // amplifier controls
  output op_mode_t         mode                 // latched mode
);

  localparam int TW = $clog2(OFF_HOLD_CNT + 1);

  initial
  begin
    if (SETTLE_CNT < 1 || OFF_HOLD_CNT < 1)
      $error("timing counts must be at least one");
    if (SETTLE_CNT > OFF_HOLD_CNT)
      $error("settle count may not exceed off hold count");
  end

  logic              pin;
  logic              pin_d;
  logic              oc;
  logic              ot;
  link_state_t       state;
  logic [2:0]        edges;
  logic [TW-1:0]     timer;
  logic [1:0]        fault_ignore;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [IRQ_W-1:0]  irq_event;
  logic              rise;
  logic              fault;
  logic              oc_d;
  logic              ot_d;
  logic              bus_done;
  logic              wr_hit;
  logic [IRQ_W-1:0]  w1c;

  pin_deglitch #(.STABLE_CYCLES(GLITCH_CNT)) u_deglitch
  (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .pin_raw   (shutdown_pulse_pin),
    .pin_clean (pin)
  );

  fault_monitor u_oc
  (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .flag_raw  (over_current_raw),
    .flag_sync (oc)
  );

  fault_monitor u_ot
  (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .flag_raw  (over_temp_raw),
    .flag_sync (ot)
  );

  assign rise  = pin & ~pin_d;
  // software may suppress a detector for test
  assign fault = (oc & ~fault_ignore[CTRL_OC_BIT])
               | (ot & ~fault_ignore[CTRL_OT_BIT]);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_d <= 1'b0;
      oc_d  <= 1'b0;
      ot_d  <= 1'b0;
    end
    else
    begin
      pin_d <= pin;
      oc_d  <= oc;
      ot_d  <= ot;
    end
  end

  // pulse counting and mode latch
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= ST_SHUTDOWN;
      edges <= 3'h0;
      timer <= '0;
      mode  <= MODE_NONE;
    end
    else
    begin
      case (state)
        ST_SHUTDOWN:
        begin
          edges <= 3'h0;
          timer <= '0;
          mode  <= MODE_NONE;
          if (rise)
          begin
            edges <= 3'h1;
            state <= ST_COUNT;
          end
        end
        ST_COUNT:
        begin
          if (rise)
          begin
            timer <= '0;
            if (edges != 3'(MAX_EDGES))
              edges <= edges + 3'h1;
          end
          else if (!pin)
          begin
            if (timer == TW'(OFF_HOLD_CNT - 1))
              state <= ST_SHUTDOWN;
            else if (pin_d)
              timer <= '0;
            else
              timer <= timer + 1'b1;
          end
          else if (timer == TW'(SETTLE_CNT - 1))
          begin
            timer <= '0;
            mode  <= op_mode_t'(edges);
            state <= fault ? ST_FAULT : ST_RUN;
          end
          else
            timer <= timer + 1'b1;
        end
        ST_RUN, ST_FAULT:
        begin
          // further pulses ignored while latched
          if (!pin)
          begin
            if (pin_d)
              timer <= '0;
            else if (timer == TW'(OFF_HOLD_CNT - 1))
              state <= ST_SHUTDOWN;
            else
              timer <= timer + 1'b1;
          end
          else
            timer <= '0;
          if (pin || timer != TW'(OFF_HOLD_CNT - 1))
          begin
            if (fault)
              state <= ST_FAULT;
            else
              state <= ST_RUN;
          end
        end
        default:
          state <= ST_SHUTDOWN;
      endcase
    end
  end

  // amplifier control follows state and latched mode
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      amp_ctrl <= '0;
    else
    begin
      amp_ctrl.enable     <= (state == ST_RUN) && !fault;
      amp_ctrl.limiter_on <= (mode != MODE_OFF) && (mode != MODE_NONE);
      case (mode)
        MODE_1P2W: amp_ctrl.power_level <= 2'h0;
        MODE_1W:   amp_ctrl.power_level <= 2'h1;
        MODE_0P8W: amp_ctrl.power_level <= 2'h2;
        default:   amp_ctrl.power_level <= 2'h0;
      endcase
    end
  end

  assign irq_event[IRQ_LATCH_BIT] = (state == ST_COUNT) && pin
                                  && (timer == TW'(SETTLE_CNT - 1)) && !rise;
  assign irq_event[IRQ_SHUTDOWN_PULSE_PIN_BIT]  = (state != ST_SHUTDOWN) && !pin && !pin_d
                                  && (timer == TW'(OFF_HOLD_CNT - 1));
  assign irq_event[IRQ_OC_BIT]    = oc & ~oc_d;
  assign irq_event[IRQ_OT_BIT]    = ot & ~ot_d;

  // avalon slave: one wait cycle, answer on second edge
  assign wr_hit = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign w1c    = (wr_hit && avs_address == OFS_IRQ)
                ? avs_writedata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      bus_done <= 1'b0;
    else
      bus_done <= (avs_read || avs_write) && !bus_done;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= !((avs_read || avs_write) && !bus_done);
  end

  // set wins over a simultaneous clear
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat <= '0;
    else
      irq_stat <= (irq_stat & ~w1c) | irq_event;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_mask     <= MASK_RESET;
      fault_ignore <= 2'h0;
    end
    else if (wr_hit && avs_address == OFS_MASK)
      irq_mask <= avs_writedata[IRQ_W-1:0];
    else if (wr_hit && avs_address == OFS_CTRL)
      fault_ignore <= avs_writedata[1:0];
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      avs_readdata <= 32'h0;
    else if (avs_read && !bus_done)
    begin
      case (avs_address)
        OFS_CTRL:   avs_readdata <= {30'h0, fault_ignore};
        OFS_STATUS: avs_readdata <= {20'h0, ot, oc, pin, edges,
                                     state, mode};
        OFS_IRQ:    avs_readdata <= {28'h0, irq_stat};
        OFS_MASK:   avs_readdata <= {28'h0, irq_mask};
        default:    avs_readdata <= 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_stat & irq_mask);
  end

endmodule

//--- sim/pulse_count_mode_select_assertions.sv
`timescale 1ns/1ps
module pulse_count_mode_select_assertions
  import pulse_mode_pkg::*;
#(
  parameter int SETTLE_CNT   = SETTLE_CYCLES,
  parameter int OFF_HOLD_CNT = OFF_HOLD_CYCLES,
  parameter int GLITCH_CNT   = DEGLITCH_CYCLES
)
(
  input wire logic      clk_sys,            // clock
  input wire logic      arst_n,             // reset
  input wire logic      shutdown_pulse_pin, // pin
  input wire logic      over_current_raw,   // short
  input wire logic      over_temp_raw,      // heat
  input wire amp_ctrl_t amp_ctrl,           // amp
  input wire op_mode_t  mode                // mode
);
  localparam int HI_OK = SETTLE_CNT + GLITCH_CNT + 8;
  localparam int LO_OK = OFF_HOLD_CNT + GLITCH_CNT + 8;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  // lengths of the current pin level run
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      hi_cnt <= 16'h0;
      lo_cnt <= 16'h0;
    end
    else
    begin
      hi_cnt <= !shutdown_pulse_pin ? 16'h0 : hi_cnt + 16'(~&hi_cnt);
      lo_cnt <= shutdown_pulse_pin ? 16'h0 : lo_cnt + 16'(~&lo_cnt);
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_settled;
    shutdown_pulse_pin && hi_cnt >= HI_OK && mode != MODE_NONE;
  endsequence
  property p_off;
    lo_cnt >= LO_OK |-> !amp_ctrl.enable && !amp_ctrl.limiter_on
      && mode == MODE_NONE;
  endproperty
  a_off: assert property (p_off)
    else $error("not shut down");
  property p_kept;
    hi_cnt >= 16'h8 && mode != MODE_NONE |=> $stable(mode);
  endproperty
  a_kept: assert property (p_kept)
    else $error("latched mode moved");
  property p_level;
    (mode inside {MODE_1P2W, MODE_1W, MODE_0P8W}) [*3]
      |-> amp_ctrl.power_level == 2'(mode - 3'h1);
  endproperty
  a_level: assert property (p_level)
    else $error("wrong power level");
  property p_nolimit;
    (mode == MODE_OFF) [*3] |-> !amp_ctrl.limiter_on;
  endproperty
  a_nolimit: assert property (p_nolimit)
    else $error("limiter on in mode 4");
  property p_latch;
    hi_cnt == HI_OK |-> mode != MODE_NONE;
  endproperty
  a_latch: assert property (p_latch)
    else $error("mode not latched");
  property p_oc;
    over_current_raw [*4] |-> !amp_ctrl.enable;
  endproperty
  a_oc: assert property (p_oc)
    else $error("on during short");
  property p_ot;
    over_temp_raw [*4] |-> !amp_ctrl.enable;
  endproperty
  a_ot: assert property (p_ot)
    else $error("on while hot");
  property p_oc_back;
    $fell(over_current_raw) && !over_temp_raw ##0 s_settled
      |-> ##[1:8] amp_ctrl.enable;
  endproperty
  a_oc_back: assert property (p_oc_back)
    else $error("no recovery after short");
  property p_ot_back;
    $fell(over_temp_raw) && !over_current_raw ##0 s_settled
      |-> ##[1:8] amp_ctrl.enable;
  endproperty
  a_ot_back: assert property (p_ot_back)
    else $error("no recovery after heat");
endmodule

bind pulse_count_mode_select pulse_count_mode_select_assertions #(
  .SETTLE_CNT(SETTLE_CNT),
  .OFF_HOLD_CNT(OFF_HOLD_CNT),
  .GLITCH_CNT(GLITCH_CNT)
) u_chk (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .shutdown_pulse_pin(shutdown_pulse_pin),
  .over_current_raw(over_current_raw),
  .over_temp_raw(over_temp_raw),
  .amp_ctrl(amp_ctrl),
  .mode(mode)
);

//--- sim/host_pin_model.sv
`timescale 1ns/1ps
module host_pin_model
#(
  parameter int WIDTH   = 6,
  parameter int OFF_LEN = 80
)
(
  input  wire logic clk_sys, // clock
  output logic      pin      // control pin
);
  initial pin = 1'b0;
  // pulses of WIDTH cycles; the pin stays high after the last
  task automatic train(input int n);
    for (int i = 0; i < n && i < 4; i++)
    begin
      if (i > 0)
      begin
        pin <= 1'b0;
        repeat (WIDTH) @(posedge clk_sys);
      end
      pin <= 1'b1;
      repeat (WIDTH) @(posedge clk_sys);
    end
  endtask
  task automatic park();
    @(posedge clk_sys);
    pin <= 1'b0;
    repeat (OFF_LEN) @(posedge clk_sys);
  endtask
  task automatic spike();
    @(posedge clk_sys);
    pin <= 1'b1;
    @(posedge clk_sys);
    pin <= 1'b0;
  endtask
endmodule

//--- sim/pulse_count_mode_select_tb.sv
`timescale 1ns/1ps
module pulse_count_mode_select_tb
  import pulse_mode_pkg::*;
;
  localparam int WAIT = 34;
  logic        clk_sys = 1'b0;
  logic        arst_n, pin, oc, ot, rd_dummy;
  logic        avs_read, avs_write, avs_waitrequest, irq;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  amp_ctrl_t   amp;
  op_mode_t    mode;
  int          fails, checks, cyc;

  always #10 clk_sys = ~clk_sys;

  host_pin_model u_host (.clk_sys(clk_sys), .pin(pin));

  pulse_count_mode_select #(
    .SETTLE_CNT(20),
    .OFF_HOLD_CNT(50),
    .GLITCH_CNT(2)
  ) u_dut (
    .clk_sys(clk_sys), .arst_n(arst_n), .shutdown_pulse_pin(pin),
    .over_current_raw(oc), .over_temp_raw(ot),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .amp_ctrl(amp), .mode(mode)
  );

  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", s, e, g);
    end
  endtask

  task automatic bus(input logic we, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_write     <= we;
    avs_read      <= !we;
    avs_writedata <= d;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", 32'h0, 32'(n >= 100));
  endtask

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  initial
  begin
    arst_n = 1'b0;
    {oc, ot, avs_read, avs_write} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    chk("mode", 32'(MODE_NONE), 32'(mode));
    bus(1'b0, OFS_MASK, 32'h0, rd);
    chk("mask", 32'(MASK_RESET), 32'(rd[3:0]));
    for (int n = 1; n <= 4; n++)
    begin
      u_host.park();
      chk("idle", 32'h0, 32'({mode, amp.enable}));
      u_host.train(n);
      repeat (WAIT) @(posedge clk_sys);
      chk("mode", 32'(n), 32'(mode));
      chk("level", 32'(n == 4 ? 0 : n - 1), 32'(amp.power_level));
      chk("limit", 32'(n != 4), 32'(amp.limiter_on));
      chk("enable", 32'h1, 32'(amp.enable));
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status", 32'(n), 32'(rd[2:0]));
    end
    u_host.train(2);
    repeat (WAIT) @(posedge clk_sys);
    chk("kept", 32'(MODE_OFF), 32'(mode));
    u_host.park();
    u_host.spike();
    repeat (WAIT) @(posedge clk_sys);
    chk("glitch", 32'(MODE_NONE), 32'(mode));
    u_host.train(1);
    repeat (WAIT) @(posedge clk_sys);
    for (int f = 1; f <= 2; f++)
    begin
      {ot, oc} <= 2'(f);
      repeat (8) @(posedge clk_sys);
      chk("fault off", 32'h0, 32'(amp.enable));
      {ot, oc} <= 2'h0;
      repeat (8) @(posedge clk_sys);
      chk("fault back", 32'h1, 32'(amp.enable));
    end
    bus(1'b1, OFS_IRQ, 32'hF, rd);
    bus(1'b1, OFS_MASK, 32'h1, rd);
    repeat (3) @(posedge clk_sys);
    chk("irq idle", 32'h0, 32'(irq));
    u_host.park();
    u_host.train(1);
    repeat (WAIT) @(posedge clk_sys);
    chk("irq set", 32'h1, 32'(irq));
    bus(1'b1, OFS_IRQ, 32'h1, rd);
    repeat (3) @(posedge clk_sys);
    chk("irq clear", 32'h0, 32'(irq));
    bus(1'b0, OFS_IRQ, 32'h0, rd);
    chk("irq bits", 32'h2, 32'(rd[1:0]));
    avs_byteenable <= 4'h0;
    bus(1'b1, OFS_MASK, 32'hF, rd);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_MASK, 32'h0, rd);
    chk("lane off", 32'h1, 32'(rd[3:0]));
    bus(1'b1, 4'h2, 32'hF, rd);
    bus(1'b0, 4'h2, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    tally_and_finish();
  end
endmodule
